/* File: scs_pkg.sv */
// Shared constants, field layouts and types of the command sequencer block
package scs_pkg;
   // ==================== Timing ====================
   localparam int CLK_HZ        = 100_000_000;
   localparam int SEC_S         = 1;
   localparam int DIR_PULSE_MS  = 1000;
   localparam int SEQ_PULSE_MS  = 8;
   localparam int SEC_CYC       = SEC_S * CLK_HZ;
   localparam int DIR_PULSE_CYC = DIR_PULSE_MS * (CLK_HZ / 1000);
   localparam int SEQ_PULSE_CYC = SEQ_PULSE_MS * (CLK_HZ / 1000);
   localparam int CNT_W         = 27;
   // ==================== Message layout ====================
   localparam logic [2:0] SYNC_CODE = 3'h5;
   localparam logic [5:0] MSG_LAST  = 6'h22;   // 35 bits, index of last
   localparam logic [5:0] SYNC_LAST = 6'h02;
   localparam logic [3:0] ZERO_RUN  = 4'hc;
   localparam logic [2:0] SA_DEC_A  = 3'h0;
   localparam logic [2:0] SA_DEC_B  = 3'h1;
   localparam logic [2:0] SA_DAUT   = 3'h2;
   localparam logic [2:0] SA_SEQ    = 3'h3;
   localparam int MODE_QUANT = 0;              // Cell carries quantitative data
   localparam int MODE_MANV  = 1;              // Maneuver, needs ground verify
   localparam logic [7:0] DATA_AREA = 8'h80;   // Cells 128..255 never execute
   // Received MSB first: sync, address, p0, type, p1, data, p2
   typedef struct packed {
      logic [2:0]  sync;
      logic [2:0]  addr;
      logic        p0;
      logic [7:0]  ctype;
      logic        p1;
      logic [17:0] data;
      logic        p2;
   } scs_msg_t;
   typedef struct packed {
      logic        verify;
      logic [2:0]  mode;
      logic [13:0] tag;
   } scs_cell_t;
   typedef enum logic [1:0] {
      RX_HUNT_ZERO = 2'b00,
      RX_HUNT_SYNC = 2'b01,
      RX_BODY      = 2'b10
   } scs_rx_t;
   // ==================== Telemetry and registers ====================
   localparam logic [8:0] TLM_TIME_SLOT = 9'h100;
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STAT   = 8'h04;
   localparam logic [7:0] REG_ETIME  = 8'h08;
   localparam logic [7:0] REG_MSGCNT = 8'h0c;
   localparam int ST_PARERR = 2;
   // Phase increments, 32-bit accumulator at CLK_HZ, [rate group][output]
   localparam logic [31:0] NCO_INC [0:3][0:3] = '{
      '{32'h0002af32, 32'h0060a302, 32'h00305181, 32'h001828c1},
      '{32'h00015799, 32'h00305181, 32'h001828c1, 32'h000c1460},
      '{32'h0000abcd, 32'h001828c1, 32'h000c1460, 32'h00060a30},
      '{32'h0000157a, 32'h00030518, 32'h0001828c, 32'h0000c146}};
endpackage

/* File: scs_top.sv */
// Command intake, stored command sequencer and telemetry readout
`timescale 1ns/10ps
`default_nettype none
module scs_top
   import scs_pkg::*;
#(
   parameter int SEC_CYCLES = SEC_CYC,
   parameter int DIR_CYCLES = DIR_PULSE_CYC,
   parameter int SEQ_CYCLES = SEQ_PULSE_CYC
) (
   // Clock and reset
   input  wire logic          clk_in,
   input  wire logic          rst_in,
   // Command detector link
   input  wire logic          cmd_data_in,
   input  wire logic          bit_sync_in,
   input  wire logic          lock_in,
   // Telemetry
   input  wire logic          tlm_eos_in,
   output logic [17:0]        tlm_word_out,
   output logic               tlm_time_out,
   output logic [25:0]        elapsed_time_out,
   output logic [1:0]         rate_sel_out,
   output logic [3:0]         freq_out,
   // Discretes and quantitative data
   output logic [127:0]       discrete_out,
   output logic [7:0]         daut_cmd_out,
   output logic               daut_strobe_out,
   output logic [17:0]        quant_word_out,
   output logic               quant_strobe_out,
   // AHB-Lite slave
   input  wire logic          hsel_in,
   input  wire logic [31:0]   haddr_in,
   input  wire logic [1:0]    htrans_in,
   input  wire logic          hwrite_in,
   input  wire logic [2:0]    hsize_in,
   input  wire logic [31:0]   hwdata_in,
   input  wire logic          hready_in,
   output logic [31:0]        hrdata_out,
   output logic               hreadyout_out,
   output logic               hresp_out
);
   // ==================== Pin synchronisers ====================
   logic [3:0] s1_reg, s2_reg;
   logic       bs_d_reg, eos_d_reg;
   logic       dat_s, bs_s, lock_s, eos_s, bit_edge, eos_edge;
   // First stage feeds only the second stage
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s1_reg <= 4'h0;
         s2_reg <= 4'h0;
      end else begin
         s1_reg <= {tlm_eos_in, lock_in, bit_sync_in, cmd_data_in};
         s2_reg <= s1_reg;
      end
   end
   assign {eos_s, lock_s, bs_s, dat_s} = s2_reg;
   // Rising edges of bit sync and end of sample
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         bs_d_reg  <= 1'b0;
         eos_d_reg <= 1'b0;
      end else begin
         bs_d_reg  <= bs_s;
         eos_d_reg <= eos_s;
      end
   end
   assign bit_edge = bs_s & ~bs_d_reg;
   assign eos_edge = eos_s & ~eos_d_reg;

   // ==================== Serial receiver ====================
   scs_rx_t    rx_state;
   logic [34:0] sh_reg;
   logic [34:0] sh_next;
   logic [5:0]  bcnt_reg;
   logic [3:0]  zcnt_reg;
   logic        msg_v_reg;
   scs_msg_t    msg;
   assign sh_next = {sh_reg[33:0], dat_s};
   assign msg     = scs_msg_t'(sh_reg);
   // Lock loss drops alignment; realigning needs the zero run again
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_state  <= RX_HUNT_ZERO;
         sh_reg    <= '0;
         bcnt_reg  <= 6'h0;
         zcnt_reg  <= 4'h0;
         msg_v_reg <= 1'b0;
      end else begin
         msg_v_reg <= 1'b0;
         if (!lock_s) begin
            rx_state <= RX_HUNT_ZERO;
            zcnt_reg <= 4'h0;
         end else if (bit_edge) begin
            sh_reg <= sh_next;
            case (rx_state)
               RX_HUNT_ZERO: begin
                  zcnt_reg <= dat_s ? 4'h0 : zcnt_reg + 4'h1;
                  if (!dat_s && zcnt_reg == ZERO_RUN - 4'h1) begin
                     rx_state <= RX_HUNT_SYNC;
                  end
               end
               // initial sync after the zero run
               RX_HUNT_SYNC: begin
                  if (sh_next[2:0] == SYNC_CODE) begin
                     rx_state <= RX_BODY;
                     bcnt_reg <= SYNC_LAST + 6'h1;
                  end
               end
               RX_BODY: begin
                  bcnt_reg <= bcnt_reg + 6'h1;
                  if (bcnt_reg == SYNC_LAST && sh_next[2:0] != SYNC_CODE) begin
                     rx_state <= RX_HUNT_ZERO;
                     zcnt_reg <= 4'h0;
                  end
                  if (bcnt_reg == MSG_LAST) begin
                     bcnt_reg  <= 6'h0;
                     msg_v_reg <= 1'b1;
                  end
               end
               default: rx_state <= RX_HUNT_ZERO;
            endcase
         end
      end
   end

   // ==================== Message decode ====================
   logic is_dir, is_seq, par_ok, do_ver, do_store, store_manv;
   assign is_dir = msg_v_reg && lock_s && (msg.addr == SA_DEC_A || msg.addr == SA_DEC_B);
   assign is_seq = msg_v_reg && lock_s && msg.addr == SA_SEQ;
   assign par_ok = ~^{msg.addr, msg.p0} & ~^{msg.ctype, msg.p1} & ~^{msg.data, msg.p2};
   assign do_ver     = is_seq && par_ok && msg.data[13:0] == 14'h0;
   assign do_store   = is_seq && par_ok && msg.data[13:0] != 14'h0;
   assign store_manv = do_store && msg.data[14 + MODE_MANV];

   // ==================== Memory ====================
   logic [17:0]  mem [0:255];
   logic [127:0] armed_reg;
   logic [6:0]   scan_reg;
   scs_cell_t    scan_cell;
   logic         seq_fire;
   // 256 by 18 store, no reset on contents
   always_ff @(posedge clk_in) begin
      // verify keeps mode and tag bits
      if (do_ver) begin
         mem[msg.ctype] <= {1'b1, mem[msg.ctype][16:0]};
      // type field is the cell address
      end else if (do_store) begin
         mem[msg.ctype] <= msg.data;
      end
   end
   // Armed marks command cells that still have to fire; store wins
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         armed_reg <= '0;
      end else begin
         if (seq_fire) begin
            armed_reg[scan_reg] <= 1'b0;
         end
         if (do_store && msg.ctype < DATA_AREA) begin
            armed_reg[msg.ctype[6:0]] <= 1'b1;
         end
      end
   end

   // ==================== Elapsed time ====================
   logic [CNT_W-1:0] sec_cnt_reg;
   logic             sec_tick;
   assign sec_tick = sec_cnt_reg == CNT_W'(SEC_CYCLES - 1);
   // elapsed time always on its output
   // 26-bit seconds, about 776 days before wrap
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sec_cnt_reg      <= '0;
         elapsed_time_out <= 26'h0;
      end else begin
         sec_cnt_reg <= sec_tick ? '0 : sec_cnt_reg + 1'b1;
         if (sec_tick) begin
            elapsed_time_out <= elapsed_time_out + 26'h1;
         end
      end
   end

   // ==================== Scanner and pulse engine ====================
   logic             dir_pend_reg, busy_reg;
   logic [6:0]       dir_line_reg;
   logic [CNT_W-1:0] pcnt_reg;
   logic             start_dir;
   assign scan_cell = scs_cell_t'(mem[{1'b0, scan_reg}]);
   // maneuver cells need their verify bit
   assign seq_fire = !busy_reg && !dir_pend_reg && lock_s && armed_reg[scan_reg]
                     && scan_cell.tag == elapsed_time_out[13:0]
                     && (!scan_cell.mode[MODE_MANV] || scan_cell.verify);
   assign start_dir = !busy_reg && dir_pend_reg && lock_s;
   // One discrete at a time; a direct command waits for a running pulse
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         dir_pend_reg     <= 1'b0;
         dir_line_reg     <= 7'h0;
         busy_reg         <= 1'b0;
         pcnt_reg         <= '0;
         scan_reg         <= 7'h0;
         discrete_out     <= '0;
         quant_word_out   <= 18'h0;
         quant_strobe_out <= 1'b0;
         daut_cmd_out     <= 8'h0;
         daut_strobe_out  <= 1'b0;
      end else begin
         quant_strobe_out <= 1'b0;
         daut_strobe_out  <= 1'b0;
         if (is_dir && msg.ctype < DATA_AREA) begin
            dir_pend_reg <= 1'b1;
            dir_line_reg <= msg.ctype[6:0];
         end
         if (msg_v_reg && lock_s && msg.addr == SA_DAUT) begin
            daut_cmd_out    <= msg.ctype;
            daut_strobe_out <= 1'b1;
         end
         if (!busy_reg && !seq_fire) begin
            scan_reg <= scan_reg + 7'h1;
         end
         // direct pulse starts after decode once no pulse is running
         if (start_dir) begin
            dir_pend_reg <= 1'b0;
            busy_reg     <= 1'b1;
            pcnt_reg     <= CNT_W'(DIR_CYCLES - 1);
            discrete_out <= 128'h1 << dir_line_reg;
         end else if (seq_fire) begin
            busy_reg     <= 1'b1;
            pcnt_reg     <= CNT_W'(SEQ_CYCLES - 1);
            discrete_out <= 128'h1 << scan_reg;
            // companion data cell goes out with the command
            if (scan_cell.mode[MODE_QUANT]) begin
               quant_word_out   <= mem[{1'b1, scan_reg}];
               quant_strobe_out <= 1'b1;
            end
         // pulse held for its full count
         end else if (busy_reg) begin
            pcnt_reg <= pcnt_reg - 1'b1;
            if (pcnt_reg == '0) begin
               busy_reg     <= 1'b0;
               discrete_out <= '0;
            end
         end
      end
   end

   // ==================== Telemetry readout ====================
   logic [8:0] tptr_reg;
   logic       prio_v_reg;
   logic [7:0] prio_a_reg;
   // newest maneuver word jumps the queue; new set wins
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         prio_v_reg <= 1'b0;
         prio_a_reg <= 8'h0;
      end else if (store_manv) begin
         prio_v_reg <= 1'b1;
         prio_a_reg <= msg.ctype;
      end else if (eos_edge) begin
         prio_v_reg <= 1'b0;
      end
   end
   // word changes only after end of sample
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tptr_reg     <= TLM_TIME_SLOT;
         tlm_word_out <= 18'h0;
         tlm_time_out <= 1'b0;
      end else if (eos_edge) begin
         if (prio_v_reg) begin
            tlm_word_out <= mem[prio_a_reg];
            tlm_time_out <= 1'b0;
         end else if (tptr_reg == TLM_TIME_SLOT) begin
            tlm_word_out <= elapsed_time_out[17:0];
            tlm_time_out <= 1'b1;
            tptr_reg     <= 9'h0;
         end else begin
            tlm_word_out <= mem[tptr_reg[7:0]];
            tlm_time_out <= 1'b0;
            tptr_reg     <= tptr_reg + 9'h1;
         end
      end
   end

   // ==================== Rate group frequencies ====================
   logic [1:0]  ctrl_reg;
   logic [31:0] acc_reg [0:3];
   // one accumulator per output of the group
   for (genvar k = 0; k < 4; k++) begin : g_nco
      always_ff @(posedge clk_in or posedge rst_in) begin
         if (rst_in) begin
            acc_reg[k]  <= 32'h0;
            freq_out[k] <= 1'b0;
         end else begin
            acc_reg[k]  <= acc_reg[k] + NCO_INC[ctrl_reg][k];
            freq_out[k] <= acc_reg[k][31];
         end
      end
   end

   // ==================== AHB-Lite slave ====================
   logic       wr_pend_reg, parerr_reg, ap_ok;
   logic [7:0] wa_reg;
   logic [15:0] msgcnt_reg;
   assign ap_ok = hsel_in && hready_in && htrans_in[1];
   // Zero wait state: reads are prepared in the address phase
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_pend_reg   <= 1'b0;
         wa_reg        <= 8'h0;
         hrdata_out    <= 32'h0;
         hreadyout_out <= 1'b1;
         hresp_out     <= 1'b0;
      end else begin
         wr_pend_reg <= ap_ok && hwrite_in;
         wa_reg      <= haddr_in[7:0];
         if (ap_ok && !hwrite_in) begin
            case (haddr_in[7:0])
               REG_CTRL:   hrdata_out <= {30'h0, ctrl_reg};
               REG_STAT:   hrdata_out <= {28'h0, busy_reg, parerr_reg,
                                          rx_state != RX_HUNT_ZERO, lock_s};
               REG_ETIME:  hrdata_out <= {6'h0, elapsed_time_out};
               REG_MSGCNT: hrdata_out <= {16'h0, msgcnt_reg};
               default:    hrdata_out <= 32'h0;
            endcase
         end
      end
   end
   // Control writes, sticky parity error with write-one-to-clear
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_reg     <= 2'h0;
         rate_sel_out <= 2'h0;
         parerr_reg   <= 1'b0;
         msgcnt_reg   <= 16'h0;
      end else begin
         rate_sel_out <= ctrl_reg;
         if (wr_pend_reg && wa_reg == REG_CTRL) begin
            ctrl_reg <= hwdata_in[1:0];
         end
         if (wr_pend_reg && wa_reg == REG_STAT && hwdata_in[ST_PARERR]) begin
            parerr_reg <= 1'b0;
         end
         if (is_seq && !par_ok) begin
            parerr_reg <= 1'b1;
         end
         if (msg_v_reg) begin
            msgcnt_reg <= msgcnt_reg + 16'h1;
         end
      end
   end

   // ==================== Assertions ====================
   logic [17:0] prio_word;
   assign prio_word = mem[prio_a_reg];
   sequence s_dir_start;
      start_dir;
   endsequence
   sequence s_pulse_on;
      (discrete_out != '0)[*8];
   endsequence
   property p_dir_pulse;
      @(posedge clk_in) disable iff (rst_in) s_dir_start |=> s_pulse_on;
   endproperty
   hold_word_a: assert property (@(posedge clk_in) disable iff (rst_in)
      !$past(eos_edge) |-> $stable(tlm_word_out)) else $error("word changed early");
   time_slot_a: assert property (@(posedge clk_in) disable iff (rst_in)
      eos_edge && !prio_v_reg && tptr_reg == TLM_TIME_SLOT |=>
      tlm_time_out && tlm_word_out == $past(elapsed_time_out[17:0]))
      else $error("time word missing");
   prio_first_a: assert property (@(posedge clk_in) disable iff (rst_in)
      eos_edge && prio_v_reg |=> tlm_word_out == $past(prio_word) && !prio_v_reg)
      else $error("priority word skipped");
   sec_count_a: assert property (@(posedge clk_in) disable iff (rst_in)
      sec_tick |=> elapsed_time_out == $past(elapsed_time_out) + 26'h1)
      else $error("elapsed time not advanced");
   dir_pulse_a: assert property (p_dir_pulse)
      else $error("direct pulse too short");
   no_unlock_a: assert property (@(posedge clk_in) disable iff (rst_in)
      $changed(discrete_out) && discrete_out != '0 |-> $past(lock_s))
      else $error("fired without lock");
   manv_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
      seq_fire && scan_cell.mode[MODE_MANV] |=> $past(scan_cell.verify) && busy_reg)
      else $error("unverified maneuver fired");
   verify_tag_a: assert property (@(posedge clk_in) disable iff (rst_in)
      do_ver |=> mem[$past(msg.ctype)] == {1'b1, $past(mem[msg.ctype][16:0])})
      else $error("verify changed tag");
   zero_run_a: assert property (@(posedge clk_in) disable iff (rst_in)
      rx_state == RX_HUNT_ZERO ##1 rx_state == RX_HUNT_SYNC |->
      $past(zcnt_reg) == ZERO_RUN - 4'h1) else $error("sync hunt too early");
endmodule
`default_nettype wire

/* File: scs_link_model.sv */
// Behavioural command detector and telemetry sampler facing the block
`timescale 1ns/10ps
`default_nettype none
module scs_link_model (
   // Detector and telemetry lines
   output logic data_out,
   output logic sync_out,
   output logic lock_out,
   output logic eos_out
);
   // ==================== Line driving ====================
   // Idle levels: no lock, link clock standing still outside frames
   initial begin
      data_out = 1'b1;
      sync_out = 1'b0;
      lock_out = 1'b0;
      eos_out  = 1'b0;
   end
   // lock level, dropped at once on loss
   task automatic set_lock(input logic l);
      lock_out = l;
   endtask
   // one bit per 80 ns period, data settled before the edge
   task automatic put(input logic b);
      data_out = b;
      #30;
      sync_out = 1'b1;
      #40;
      sync_out = 1'b0;
      #10;
   endtask
   // zero run, then the message MSB first
   task automatic send(input int zeros, input logic [34:0] m);
      for (int i = 0; i < zeros; i++) put(1'b0);
      for (int i = 34; i >= 0; i--) put(m[i]);
      // Released line shows the inverse so a stale bit never passes
      data_out = ~data_out;
   endtask
   // end of sample once the word has been taken
   task automatic sample();
      eos_out = 1'b1;
      #60;
      eos_out = 1'b0;
      #60;
   endtask
endmodule
`default_nettype wire

/* File: scs_top_tb.sv */
// Self-checking bench for the command sequencer block
`timescale 1ns/10ps
`default_nettype none
module scs_top_tb;
   import scs_pkg::*;
   logic          clk_in = 1'b0;
   logic          rst_in = 1'b1;
   logic          hsel = 1'b0;
   logic          hwrite = 1'b0;
   logic [1:0]    htrans = 2'h0;
   logic [31:0]   haddr = 32'h0;
   logic [31:0]   hwdata = 32'h0;
   logic [31:0]   hrdata, rd;
   logic          hready, hresp, ttime, cd, bs, lk, eos;
   logic [17:0]   tword;
   logic [25:0]   etime;
   logic [1:0]    rsel;
   logic [127:0]  disc;
   logic [7:0]    dcmd;
   logic [7:0]    dlast = 8'h0;
   logic          dstb;
   logic [13:0]   tg;
   int            n_fail = 0;
   int            n_tests = 0;
   int            cyc = 0;
   int            len;
   // Short second and pulse counts keep the run brief; a second must outlast a scan pass
   scs_top #(.SEC_CYCLES(200), .DIR_CYCLES(40), .SEQ_CYCLES(12)) dut (
      .clk_in(clk_in), .rst_in(rst_in), .cmd_data_in(cd), .bit_sync_in(bs),
      .lock_in(lk), .tlm_eos_in(eos), .tlm_word_out(tword), .tlm_time_out(ttime),
      .elapsed_time_out(etime), .rate_sel_out(rsel), .freq_out(), .discrete_out(disc),
      .daut_cmd_out(dcmd), .daut_strobe_out(dstb), .quant_word_out(), .quant_strobe_out(),
      .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
      .hreadyout_out(hready), .hresp_out(hresp));
   scs_link_model lnk (.data_out(cd), .sync_out(bs), .lock_out(lk), .eos_out(eos));
   // ==================== Helpers ====================
   // Science unit strobe lasts one cycle, so keep the last command it carried
   always @(posedge clk_in) begin
      if (dstb === 1'b1) dlast <= dcmd;
   end
   // Clock and hang guard
   initial forever #5 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         conclude();
      end
   end
   task automatic conclude();
      $display("tests %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         $display("[FAIL] %0t %s", $time, m);
         n_fail++;
      end
   endtask
   // One AHB single transfer; entered just after a rising edge
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge clk_in);
      while (hready !== 1'b1) @(posedge clk_in);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk_in);
      while (hready !== 1'b1) @(posedge clk_in);
      rd = hrdata;
   endtask
   // Even parity per field, sync in front
   function automatic logic [34:0] mk(input logic [2:0] a, input logic [7:0] t,
                                      input logic [17:0] d);
      return {SYNC_CODE, a, ^a, t, ^t, d, ^d};
   endfunction
   // Counts the cycles a line stays high, stopping when it falls
   task automatic watch(input int idx, input int lim);
      len = 0;
      repeat (lim) begin
         @(posedge clk_in);
         if (disc[idx] === 1'b1) len++;
         else if (len > 0) break;
      end
   endtask
   task automatic tlm();
      lnk.sample();
      repeat (8) @(posedge clk_in);
   endtask
   // ==================== Scenarios ====================
   initial begin
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      chk(32'(hready), 32'h1, "ready after reset");
      chk(32'(tword), 32'h0, "readout after reset");
      for (int r = 0; r < 4; r++) begin
         ahb(1'b1, REG_CTRL, 32'(r));
         ahb(1'b0, REG_CTRL, 32'h0);
         chk(32'(rsel), 32'(r), "rate discrete");
      end
      ahb(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      tlm();
      chk(32'(ttime), 32'h1, "time word first");
      chk(32'(tword), 32'(etime[17:0]), "time word value");
      tlm();
      chk(32'(ttime), 32'h0, "next word after sample");
      lnk.set_lock(1'b1);
      // Watch runs beside the send so the pulse start is never missed
      fork
         lnk.send(12, mk(SA_DEC_A, 8'h05, 18'h0));
         watch(5, 500);
      join
      chk(32'(len), 32'd40, "direct pulse");
      // Zeros of a new run first break the old alignment, hence fifteen
      fork
         lnk.send(15, mk(SA_DEC_B, 8'h7f, 18'h0));
         watch(127, 500);
      join
      chk(32'(len), 32'd40, "last line");
      lnk.send(15, mk(SA_DAUT, 8'h42, 18'h0));
      repeat (4) @(posedge clk_in);
      chk(32'(dlast), 32'h42, "science unit command");
      lnk.set_lock(1'b0);
      lnk.send(12, mk(SA_DEC_A, 8'h06, 18'h0));
      watch(6, 60);
      chk(32'(len), 32'h0, "no lock");
      lnk.set_lock(1'b1);
      lnk.send(0, mk(SA_DEC_A, 8'h06, 18'h0));
      watch(6, 60);
      chk(32'(len), 32'h0, "no zero run");
      lnk.send(12, mk(SA_DEC_A, 8'h06, 18'h0) ^ {3'h2, 32'h0});
      watch(6, 60);
      chk(32'(len), 32'h0, "bad sync");
      lnk.send(15, mk(SA_SEQ, 8'h30, 18'h00123) ^ 35'h1);
      @(posedge clk_in);
      ahb(1'b0, REG_STAT, 32'h0);
      chk(32'(rd[2]), 32'h1, "parity flag");
      ahb(1'b1, REG_STAT, 32'h4);
      ahb(1'b0, REG_STAT, 32'h0);
      chk(32'(rd[2]), 32'h0, "parity clear");
      tg = etime[13:0] + 14'h8;
      fork
         lnk.send(15, mk(SA_SEQ, 8'h0a, {4'h0, tg}));
         watch(10, 2200);
      join
      chk(32'(len), 32'd12, "stored pulse");
      tg = etime[13:0] + 14'hc;
      lnk.send(15, mk(SA_SEQ, 8'h14, {4'h2, tg}));
      tlm();
      chk(32'(tword), 32'({4'h2, tg}), "maneuver first");
      fork
         lnk.send(15, mk(SA_SEQ, 8'h14, 18'h20000));
         watch(20, 380);
      join
      chk(32'(len), 32'h0, "unverified held");
      watch(20, 2000);
      chk(32'(len), 32'd12, "verified fires");
      conclude();
   end
endmodule
`default_nettype wire
